// File: rtl/fbp_pkg.sv
// Constants, types and register map of the frame buffer pointer block
package fbp_pkg;

  // Register offsets on the host interface
  localparam logic [11:0] FBP_TXQ_CMD_OFF  = 12'h080;
  localparam logic [11:0] FBP_RXQ_CMD_OFF  = 12'h082;
  localparam logic [11:0] FBP_TX_PTR_OFF   = 12'h184;
  localparam logic [11:0] FBP_RX_PTR_OFF   = 12'h186;
  localparam logic [11:0] FBP_DUR_THR_OFF  = 12'h18c;
  localparam logic [11:0] FBP_BYTE_THR_OFF = 12'h18e;
  localparam logic [11:0] FBP_ISR_OFF      = 12'h192;
  localparam logic [11:0] FBP_DATA_OFF     = 12'h2c0;

  // Field positions
  localparam int          FBP_PTR_W        = 11;
  localparam int          FBP_AUTOINC_BIT  = 14;
  localparam int          FBP_WST_BIT      = 12;
  localparam int          FBP_EMS_BIT      = 11;
  localparam int          FBP_DUR_EN_BIT   = 7;
  localparam int          FBP_BYTE_EN_BIT  = 6;
  localparam int          FBP_DMA_BIT      = 3;
  localparam int          FBP_ENQ_BIT      = 0;
  localparam int          FBP_RX_IRQ_BIT   = 13;

  // Values after reset and limits
  localparam logic        FBP_AUTOINC_RST  = 1'b0;
  localparam logic        FBP_WST_RST      = 1'b1;
  localparam logic [10:0] FBP_PTR_RST      = 11'h000;
  localparam logic [15:0] FBP_THR_RST      = 16'h0000;
  localparam logic [15:0] FBP_DUR_MAX      = 16'hcfff;

  // Timing
  localparam int          FBP_CLK_NS       = 4;
  localparam int          FBP_US_NS        = 1000;
  localparam int          FBP_US_CYCLES    = FBP_US_NS / FBP_CLK_NS;
  localparam int          FBP_FIFO_DEPTH   = 16;

  typedef enum logic [1:0] {
    FBP_SZ_BYTE,
    FBP_SZ_WORD,
    FBP_SZ_DWORD
  } fbp_size_t;

  typedef struct packed {
    logic [11:0] addr;
    logic        wr;
    logic        rd;
    fbp_size_t   size;
    logic [31:0] wdata;
  } fbp_host_req_t;

  typedef struct packed {
    logic [10:0] addr;
    fbp_size_t   size;
    logic [31:0] data;
  } fbp_tx_word_t;

endpackage

// File: rtl/fbp_usec_tick.sv
// Divider giving a one-cycle pulse every microsecond
`timescale 1ns/1ns
module fbp_usec_tick (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  output logic      tick_out
);

  localparam int CW = $clog2(fbp_pkg::FBP_US_CYCLES);
  localparam logic [CW-1:0] LAST = CW'(fbp_pkg::FBP_US_CYCLES - 1);

  logic [CW-1:0] cnt_q;
  wire           wrap = (cnt_q == LAST);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= wrap ? '0 : cnt_q + 1'b1;
    end
  end

  assign tick_out = wrap;

endmodule

// File: rtl/fbp_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
module fbp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;

  wire push = in_valid_in && in_ready_out;
  wire pop  = out_valid_out && out_ready_in;

  assign in_ready_out  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out  = mem_q[rp_q];

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wp_q] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

// File: rtl/fbp_top.sv
// Frame buffer pointers, receive thresholds and frame data access for the host port
// Operation
// - Transmit pointer addresses transmit buffer; data writes advance it when auto-increment set.
// - Each auto-increment adds one, two or four by access size.
// - Transmit auto-increment bit 14, reset 0; when clear pointer stays still.
// - Transmit pointer value bits 10..0, read-only, resets to zero.
// - Transmit enqueue command reloads transmit pointer with next free frame location.
// - Receive pointer addresses receive buffer; data reads advance it when auto-increment set.
// - Receive auto-increment bit 14, reset 0; when clear host positions pointer.
// - Bit 12 selects write sample delay, reset 1.
// - Bit 11 reports byte order from strap at reset; host writes ignored.
// - Duration threshold 16-bit, microsecond units, reset zero, at most 0xCFFF.
// - Duration enable bit 7: flag receive interrupt when timer passes threshold.
// - Byte enable bit 6: flag receive interrupt when held bytes pass threshold.
// - While DMA start set, strobes reach frame buffer; all registers blocked except the receive queue command register.
// - Receive interrupt flag holds until host writes one; reads keep it.
`timescale 1ns/1ns
module fbp_top (
  input  wire logic                  sys_clk_in,
  input  wire logic                  arst_n_in,
  input  wire fbp_pkg::fbp_host_req_t host_req_in,
  output logic                       host_wait_out,
  output logic                       host_rvalid_out,
  output logic [31:0]                host_rdata_out,
  input  wire logic                  strap_big_endian_in,
  output logic                       write_sample_select_out,
  output logic                       byte_order_select_out,
  input  wire logic [10:0]           next_tx_location_in,
  output logic                       tx_enqueue_out,
  output logic                       txbuf_valid_out,
  input  wire logic                  txbuf_ready_in,
  output fbp_pkg::fbp_tx_word_t      txbuf_word_out,
  output logic [10:0]                rxbuf_addr_out,
  input  wire logic [31:0]           rxbuf_data_in,
  input  wire logic                  rxq_empty_in,
  input  wire logic [15:0]           rxq_bytes_in,
  output logic                       rx_irq_status_out
);

  // Reset release through two flops
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Register state
  logic        tx_ai_q;
  logic [10:0] tx_ptr_q;
  logic        rx_ai_q;
  logic [10:0] rx_ptr_q;
  logic        wst_q;
  logic        ems_q;
  logic        strap_done_q;
  logic [15:0] dur_thr_q;
  logic [15:0] byte_thr_q;
  logic        dur_en_q;
  logic        byte_en_q;
  logic        dma_q;
  logic        rx_irq_q;
  logic        hit_q;
  logic [15:0] timer_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;

  // Address decode
  wire [11:0] addr = host_req_in.addr;
  wire        wr   = host_req_in.wr;
  wire        rd   = host_req_in.rd;
  wire [15:0] wd   = host_req_in.wdata[15:0];

  wire hit_rxq_cmd  = (addr == fbp_pkg::FBP_RXQ_CMD_OFF);
  // The command register stays reachable so DMA can be ended
  wire reg_open     = !dma_q || hit_rxq_cmd;
  wire hit_data     = dma_q ? !hit_rxq_cmd : (addr == fbp_pkg::FBP_DATA_OFF);
  wire hit_txq_cmd  = reg_open && (addr == fbp_pkg::FBP_TXQ_CMD_OFF);
  wire hit_tx_ptr   = reg_open && (addr == fbp_pkg::FBP_TX_PTR_OFF);
  wire hit_rx_ptr   = reg_open && (addr == fbp_pkg::FBP_RX_PTR_OFF);
  wire hit_dur      = reg_open && (addr == fbp_pkg::FBP_DUR_THR_OFF);
  wire hit_byte     = reg_open && (addr == fbp_pkg::FBP_BYTE_THR_OFF);
  wire hit_isr      = reg_open && (addr == fbp_pkg::FBP_ISR_OFF);
  wire hit_cmd_ok   = reg_open && hit_rxq_cmd;

  // Frame data path
  fbp_pkg::fbp_tx_word_t tx_word;
  wire                   fifo_ready;
  wire                   data_wr_req = wr && hit_data;
  wire                   data_wr     = data_wr_req && fifo_ready;
  wire                   data_rd     = rd && hit_data;
  // A stalled write must be held by the host until the wait drops
  assign host_wait_out = data_wr_req && !fifo_ready;

  assign tx_word.addr = tx_ptr_q;
  assign tx_word.size = host_req_in.size;
  assign tx_word.data = host_req_in.wdata;

  fbp_fifo #(
    .WIDTH ($bits(fbp_pkg::fbp_tx_word_t)),
    .DEPTH (fbp_pkg::FBP_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_in        (sys_clk_in),
    .rst_n_in      (rst_n_q),
    .in_valid_in   (data_wr),
    .in_ready_out  (fifo_ready),
    .in_data_in    (tx_word),
    .out_valid_out (txbuf_valid_out),
    .out_ready_in  (txbuf_ready_in),
    .out_data_out  (txbuf_word_out)
  );

  // Pointer step by access size, wrapping in 11 bits
  wire [10:0] step = (host_req_in.size == fbp_pkg::FBP_SZ_DWORD) ? 11'h004 :
                     (host_req_in.size == fbp_pkg::FBP_SZ_WORD)  ? 11'h002 :
                                                                   11'h001;
  wire [10:0] tx_ptr_inc = tx_ptr_q + step;
  wire [10:0] rx_ptr_inc = rx_ptr_q + step;

  wire tx_enq    = wr && hit_txq_cmd && wd[fbp_pkg::FBP_ENQ_BIT];
  wire tx_ai_wr  = wr && hit_tx_ptr;
  wire rx_ptr_wr = wr && hit_rx_ptr;

  assign tx_enqueue_out = tx_enq;

  // Transmit pointer register
  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_ai_q  <= fbp_pkg::FBP_AUTOINC_RST;
      tx_ptr_q <= fbp_pkg::FBP_PTR_RST;
    end else begin
      if (tx_ai_wr) begin
        tx_ai_q <= wd[fbp_pkg::FBP_AUTOINC_BIT];
      end
      if (tx_enq) begin
        tx_ptr_q <= next_tx_location_in;
      end else if (data_wr && tx_ai_q) begin
        tx_ptr_q <= tx_ptr_inc;
      end
    end
  end

  // Receive pointer register
  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rx_ai_q  <= fbp_pkg::FBP_AUTOINC_RST;
      rx_ptr_q <= fbp_pkg::FBP_PTR_RST;
      wst_q    <= fbp_pkg::FBP_WST_RST;
    end else begin
      if (rx_ptr_wr) begin
        rx_ai_q  <= wd[fbp_pkg::FBP_AUTOINC_BIT];
        wst_q    <= wd[fbp_pkg::FBP_WST_BIT];
        // Host must zero this before each DMA read
        rx_ptr_q <= wd[10:0];
      end else if (data_rd && rx_ai_q) begin
        rx_ptr_q <= rx_ptr_inc;
      end
    end
  end

  // Byte order strap, caught once after the reset release
  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      strap_done_q <= 1'b0;
      ems_q        <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      ems_q        <= strap_big_endian_in;
    end
  end

  assign rxbuf_addr_out          = rx_ptr_q;
  assign write_sample_select_out = wst_q;
  assign byte_order_select_out   = ems_q;

  // Thresholds and receive queue command bits
  wire [15:0] dur_wr_val = (wd > fbp_pkg::FBP_DUR_MAX) ? fbp_pkg::FBP_DUR_MAX : wd;

  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dur_thr_q  <= fbp_pkg::FBP_THR_RST;
      byte_thr_q <= fbp_pkg::FBP_THR_RST;
      dur_en_q   <= 1'b0;
      byte_en_q  <= 1'b0;
      dma_q      <= 1'b0;
    end else begin
      if (wr && hit_dur) begin
        dur_thr_q <= dur_wr_val;
      end
      if (wr && hit_byte) begin
        byte_thr_q <= wd;
      end
      if (wr && hit_cmd_ok) begin
        dur_en_q  <= wd[fbp_pkg::FBP_DUR_EN_BIT];
        byte_en_q <= wd[fbp_pkg::FBP_BYTE_EN_BIT];
        dma_q     <= wd[fbp_pkg::FBP_DMA_BIT];
      end
    end
  end

  // Microsecond duration timer
  wire us_tick;

  fbp_usec_tick u_tick (
    .clk_in   (sys_clk_in),
    .rst_n_in (rst_n_q),
    .tick_out (us_tick)
  );

  // Saturates rather than wrapping, so a long wait cannot fall back under
  wire timer_max = (timer_q == 16'hffff);

  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      timer_q <= 16'h0000;
    end else if (rxq_empty_in) begin
      timer_q <= 16'h0000;
    end else if (us_tick && !timer_max) begin
      timer_q <= timer_q + 16'h0001;
    end
  end

  // Receive interrupt flag
  wire dur_hit  = dur_en_q && !rxq_empty_in && (timer_q > dur_thr_q);
  wire byte_hit = byte_en_q && (rxq_bytes_in > byte_thr_q);
  wire any_hit  = dur_hit || byte_hit;
  wire irq_set  = any_hit && !hit_q;
  wire irq_clr  = wr && hit_isr && wd[fbp_pkg::FBP_RX_IRQ_BIT];

  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      hit_q    <= 1'b0;
      rx_irq_q <= 1'b0;
    end else begin
      hit_q <= any_hit;
      // Set beats a clear in the same cycle
      if (irq_set) begin
        rx_irq_q <= 1'b1;
      end else if (irq_clr) begin
        rx_irq_q <= 1'b0;
      end
    end
  end

  assign rx_irq_status_out = rx_irq_q;

  // Read data, reserved bits read as zero
  wire [15:0] tx_ptr_rd = {
    1'b0,
    tx_ai_q,
    3'b000,
    tx_ptr_q
  };
  // Receive pointer value is write-only and reads as zero
  wire [15:0] rx_ptr_rd = {
    1'b0,
    rx_ai_q,
    1'b0,
    wst_q,
    ems_q,
    11'h000
  };
  wire [15:0] cmd_rd    = {
    8'h00,
    dur_en_q,
    byte_en_q,
    2'b00,
    dma_q,
    3'b000
  };
  wire [15:0] isr_rd    = {
    2'b00,
    rx_irq_q,
    13'h0000
  };

  wire [31:0] rdata_d = data_rd    ? rxbuf_data_in :
                        hit_tx_ptr ? {16'h0000, tx_ptr_rd} :
                        hit_rx_ptr ? {16'h0000, rx_ptr_rd} :
                        hit_dur    ? {16'h0000, dur_thr_q} :
                        hit_byte   ? {16'h0000, byte_thr_q} :
                        hit_cmd_ok ? {16'h0000, cmd_rd} :
                        hit_isr    ? {16'h0000, isr_rd} :
                                     32'h0000_0000;

  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
    end else begin
      rvalid_q <= rd;
      if (rd) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign host_rvalid_out = rvalid_q;
  assign host_rdata_out  = rdata_q;

endmodule

// File: verification/fbp_top_assertions.sv
// Port-level assertions for the frame buffer pointer block
`timescale 1ns/1ns
module fbp_top_chk (
  input wire logic                   sys_clk_in,
  input wire logic                   arst_n_in,
  input wire fbp_pkg::fbp_host_req_t host_req_in,
  input wire logic                   host_wait_out,
  input wire logic                   host_rvalid_out,
  input wire logic                   byte_order_select_out,
  input wire logic                   tx_enqueue_out,
  input wire logic                   txbuf_valid_out,
  input wire logic                   txbuf_ready_in,
  input wire fbp_pkg::fbp_tx_word_t  txbuf_word_out,
  input wire logic [10:0]            rxbuf_addr_out,
  input wire logic                   rxq_empty_in,
  input wire logic [15:0]            rxq_bytes_in,
  input wire logic                   rx_irq_status_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  wire [11:0] a = host_req_in.addr;
  wire        dwr = host_req_in.wr && a == fbp_pkg::FBP_DATA_OFF && !host_wait_out;
  wire        clr = host_req_in.wr && a == fbp_pkg::FBP_ISR_OFF && host_req_in.wdata[13];
  sequence rd_taken;
    host_req_in.rd;
  endsequence
  sequence tx_stalled;
    txbuf_valid_out && !txbuf_ready_in;
  endsequence
  read_answer_a: assert property (rd_taken |=> host_rvalid_out)
    else $error("read not answered");
  lone_answer_a: assert property (host_rvalid_out |-> $past(host_req_in.rd))
    else $error("answer without read");
  wait_cause_a: assert property (host_wait_out |-> host_req_in.wr && txbuf_valid_out)
    else $error("wait without write");
  tx_push_a: assert property (dwr |=> txbuf_valid_out)
    else $error("data write not queued");
  tx_hold_a: assert property (tx_stalled |=> txbuf_valid_out && $stable(txbuf_word_out))
    else $error("queued word dropped");
  rx_step_a: assert property ($past(host_req_in.rd) && $changed(rxbuf_addr_out)
    |-> 11'(rxbuf_addr_out - $past(rxbuf_addr_out))
        == 11'(11'h001 << $past(host_req_in.size)))
    else $error("wrong pointer step");
  enq_cause_a: assert property (tx_enqueue_out |-> host_req_in.wr
    && a == fbp_pkg::FBP_TXQ_CMD_OFF && host_req_in.wdata[0])
    else $error("enqueue without command");
  irq_clear_a: assert property ($fell(rx_irq_status_out) |-> $past(clr))
    else $error("flag cleared without write");
  irq_set_a: assert property ($rose(rx_irq_status_out)
    |-> $past(!rxq_empty_in || rxq_bytes_in != 16'h0000))
    else $error("flag set with empty queue");
  strap_keep_a: assert property (host_req_in.wr |=> $stable(byte_order_select_out))
    else $error("byte order changed by write");
endmodule
bind fbp_top fbp_top_chk u_chk (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
  .host_req_in(host_req_in), .host_wait_out(host_wait_out),
  .host_rvalid_out(host_rvalid_out), .byte_order_select_out(byte_order_select_out),
  .tx_enqueue_out(tx_enqueue_out), .txbuf_valid_out(txbuf_valid_out),
  .txbuf_ready_in(txbuf_ready_in), .txbuf_word_out(txbuf_word_out),
  .rxbuf_addr_out(rxbuf_addr_out), .rxq_empty_in(rxq_empty_in),
  .rxq_bytes_in(rxq_bytes_in), .rx_irq_status_out(rx_irq_status_out));

// File: verification/fbp_far_model.sv
// Queue memory model: transmit sink with stalls and receive buffer contents
`timescale 1ns/1ns
module fbp_far_model (
  input  wire logic        clk_in,
  input  wire logic        hold_in,
  input  wire logic        slow_in,
  input  wire logic [10:0] rxbuf_addr_in,
  output logic             txbuf_ready_out,
  output logic [31:0]      rxbuf_data_out
);
  logic [7:0] lfsr_q = 8'h5a;
  always @(posedge clk_in) begin
    lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
  end
  // Slow mode accepts on about half the cycles
  assign txbuf_ready_out = !hold_in && (!slow_in || lfsr_q[0]);
  // Address folded into data so a wrong pointer shows
  assign rxbuf_data_out  = {5'h00, rxbuf_addr_in, 5'h1f, rxbuf_addr_in};
endmodule

// File: verification/frame_buffer_pointer_and_rx_threshold_tb.sv
// Self-checking bench for the frame buffer pointer block
`timescale 1ns/1ns
module frame_buffer_pointer_and_rx_threshold_tb;
  localparam logic [11:0] TXC = fbp_pkg::FBP_TXQ_CMD_OFF, RXC = fbp_pkg::FBP_RXQ_CMD_OFF;
  localparam logic [11:0] TXP = fbp_pkg::FBP_TX_PTR_OFF, RXP = fbp_pkg::FBP_RX_PTR_OFF;
  localparam logic [11:0] DUR = fbp_pkg::FBP_DUR_THR_OFF, BYT = fbp_pkg::FBP_BYTE_THR_OFF;
  localparam logic [11:0] INTERRUPT_STATUS_REG = fbp_pkg::FBP_ISR_OFF, DAT = fbp_pkg::FBP_DATA_OFF;
  logic clk = 0, rst_n = 0, hold = 0, slow = 0, empty = 1, ready, wt, rv, eq, tv, wss, bos, irq;
  logic [15:0] bytes = 0;
  logic        strap = 1;
  logic [10:0] nloc = 11'h7fc, rxa, tp, rp;
  logic [31:0] rdat, rxd, rdv;
  fbp_pkg::fbp_host_req_t req = '0;
  fbp_pkg::fbp_tx_word_t  tw, e;
  fbp_pkg::fbp_tx_word_t  exp_q[$];
  fbp_pkg::fbp_size_t     s;
  integer n_mismatch = 0, check_count = 0, cyc = 0, seed = 26353, i;
  always #2 clk = !clk;
  fbp_top DUT (.sys_clk_in(clk), .arst_n_in(rst_n), .host_req_in(req), .host_wait_out(wt),
    .host_rvalid_out(rv), .host_rdata_out(rdat), .strap_big_endian_in(strap),
    .write_sample_select_out(wss), .byte_order_select_out(bos), .next_tx_location_in(nloc),
    .tx_enqueue_out(eq), .txbuf_valid_out(tv), .txbuf_ready_in(ready), .txbuf_word_out(tw),
    .rxbuf_addr_out(rxa), .rxbuf_data_in(rxd), .rxq_empty_in(empty), .rxq_bytes_in(bytes),
    .rx_irq_status_out(irq));
  fbp_far_model u_far (.clk_in(clk), .hold_in(hold), .slow_in(slow), .rxbuf_addr_in(rxa),
    .txbuf_ready_out(ready), .rxbuf_data_out(rxd));
  function automatic logic [31:0] pat(input logic [10:0] x);
    return {5'h00, x, 5'h1f, x};
  endfunction
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("mismatches %0d, comparisons %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One host access; a stalled data write is held until taken
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input fbp_pkg::fbp_size_t sz);
    @(negedge clk);
    req = '{addr: a, wr: w, rd: !w, size: sz, wdata: d};
    do @(posedge clk); while (w && wt === 1'b1);
    @(negedge clk);
    req.wr = 0;
    req.rd = 0;
    rdv = rdat;
    if (!w) chk(rv, 1);
  endtask
  task automatic dwr(input fbp_pkg::fbp_size_t sz, input logic inc);
    e = '{addr: tp, size: sz, data: $random(seed)};
    exp_q.push_back(e);
    acc(1, DAT, e.data, sz);
    if (inc) tp = tp + (11'h001 << sz);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (req.wr === 1'b1 && req.addr == TXC && req.wdata[0]) chk(eq, 1);
    if (tv === 1'b1 && ready === 1'b1) begin
      if (exp_q.size() == 0) chk(tw, 48'h0);
      else chk(tw, exp_q.pop_front());
    end
    if (cyc == 20000) begin
      n_mismatch++;
      test_done;
    end
  end
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1;
    repeat (3) @(posedge clk);
    acc(0, TXP, 0, fbp_pkg::FBP_SZ_WORD); chk(rdv, 32'h0);
    acc(0, RXP, 0, fbp_pkg::FBP_SZ_WORD); chk(rdv, 32'h1800);
    chk(wss, 1);
    acc(0, DUR, 0, fbp_pkg::FBP_SZ_WORD); chk(rdv, 32'h0);
    acc(0, BYT, 0, fbp_pkg::FBP_SZ_WORD); chk(rdv, 32'h0);
    acc(0, 12'h188, 0, fbp_pkg::FBP_SZ_WORD); chk(rdv, 32'h0);
    acc(1, TXC, 1, fbp_pkg::FBP_SZ_WORD); tp = nloc;
    acc(1, TXP, 32'hffff, fbp_pkg::FBP_SZ_WORD);
    acc(0, TXP, 0, fbp_pkg::FBP_SZ_WORD); chk(rdv, {21'h8, nloc});
    hold = 1;
    for (i = 0; i < 16; i++) dwr(fbp_pkg::fbp_size_t'(i % 3), 1);
    fork
      dwr(fbp_pkg::FBP_SZ_DWORD, 1);
      begin repeat (12) @(negedge clk); chk(wt, 1); hold = 0; end
    join
    slow = 1;
    for (i = 0; i < 24; i++) begin
      s = fbp_pkg::fbp_size_t'($unsigned($random(seed)) % 3);
      dwr(s, 1);
    end
    acc(0, TXP, 0, fbp_pkg::FBP_SZ_WORD); chk(rdv, {21'h8, tp});
    acc(1, TXP, 0, fbp_pkg::FBP_SZ_WORD);
    dwr(fbp_pkg::FBP_SZ_DWORD, 0);
    acc(0, TXP, 0, fbp_pkg::FBP_SZ_WORD); chk(rdv, {21'h0, tp});
    acc(1, RXP, 32'h4000, fbp_pkg::FBP_SZ_WORD); rp = 0;
    chk(wss, 0); chk(bos, 1);
    for (i = 0; i < 10; i++) begin
      s = fbp_pkg::fbp_size_t'($unsigned($random(seed)) % 3);
      acc(0, DAT, 0, s); chk(rdv, pat(rp));
      rp = rp + (11'h001 << s);
      chk(rxa, rp);
    end
    acc(0, RXP, 0, fbp_pkg::FBP_SZ_WORD); chk(rdv, 32'h4800);
    acc(1, RXP, 32'h1005, fbp_pkg::FBP_SZ_WORD);
    acc(0, DAT, 0, fbp_pkg::FBP_SZ_WORD); chk(rdv, pat(11'h005)); chk(rxa, 11'h005);
    acc(1, RXP, 32'h4000, fbp_pkg::FBP_SZ_WORD); rp = 0;
    acc(1, DUR, 32'hffff, fbp_pkg::FBP_SZ_WORD);
    acc(0, DUR, 0, fbp_pkg::FBP_SZ_WORD); chk(rdv, 32'hcfff);
    acc(1, DUR, 3, fbp_pkg::FBP_SZ_WORD);
    acc(1, RXC, 32'h0080, fbp_pkg::FBP_SZ_WORD);
    empty = 0;
    repeat (700) @(negedge clk);
    chk(irq, 0);
    for (i = 0; i < 700 && irq !== 1'b1; i++) @(negedge clk);
    chk(irq, 1);
    acc(0, INTERRUPT_STATUS_REG, 0, fbp_pkg::FBP_SZ_WORD); chk(rdv, 32'h2000); chk(irq, 1);
    acc(1, INTERRUPT_STATUS_REG, 32'h2000, fbp_pkg::FBP_SZ_WORD); chk(irq, 0);
    empty = 1;
    acc(1, RXC, 32'h0040, fbp_pkg::FBP_SZ_WORD);
    acc(1, BYT, 100, fbp_pkg::FBP_SZ_WORD);
    bytes = 100;
    repeat (4) @(negedge clk);
    chk(irq, 0);
    bytes = 101;
    repeat (4) @(negedge clk);
    chk(irq, 1);
    acc(1, INTERRUPT_STATUS_REG, 32'h2000, fbp_pkg::FBP_SZ_WORD);
    acc(1, RXC, 32'h0008, fbp_pkg::FBP_SZ_WORD);
    e = '{addr: tp, size: fbp_pkg::FBP_SZ_WORD, data: 32'h0000a5c3};
    exp_q.push_back(e);
    acc(1, TXP, e.data, fbp_pkg::FBP_SZ_WORD);
    acc(0, DUR, 0, fbp_pkg::FBP_SZ_WORD); chk(rdv, pat(rp));
    acc(1, RXC, 0, fbp_pkg::FBP_SZ_WORD);
    acc(0, DUR, 0, fbp_pkg::FBP_SZ_WORD); chk(rdv, 32'h3);
    repeat (60) @(negedge clk);
    chk(exp_q.size(), 0);
    // Second reset with the other strap level
    strap = 0;
    rst_n = 0;
    repeat (3) @(negedge clk);
    rst_n = 1;
    repeat (3) @(negedge clk);
    chk(bos, 0);
    chk(wss, 1);
    acc(0, RXP, 0, fbp_pkg::FBP_SZ_WORD); chk(rdv, 32'h1000);
    acc(0, TXP, 0, fbp_pkg::FBP_SZ_WORD); chk(rdv, 32'h0);
    test_done;
  end
endmodule
